// file: core/bto_talker.sv
`include "bto_params.svh"
`default_nettype none

module bto_talker (
    input  wire logic                  aclk,     // System clock, 10 MHz.
    input  wire logic                  aresetn,  // Synchronous reset, active low.
    input  wire logic                  awvalid,  // Write address valid.
    output logic                       awready,  // Write address ready.
    input  wire logic [7:0]            awaddr,   // Write byte address.
    input  wire logic [2:0]            awprot,   // Write protection, unused.
    input  wire logic                  wvalid,   // Write data valid.
    output logic                       wready,   // Write data ready.
    input  wire logic [31:0]           wdata,    // Write data.
    input  wire logic [3:0]            wstrb,    // Write byte strobes.
    output var  logic                  bvalid,   // Write response valid.
    input  wire logic                  bready,   // Write response ready.
    output var  logic [1:0]            bresp,    // Write response.
    input  wire logic                  arvalid,  // Read address valid.
    output logic                       arready,  // Read address ready.
    input  wire logic [7:0]            araddr,   // Read byte address.
    input  wire logic [2:0]            arprot,   // Read protection, unused.
    output var  logic                  rvalid,   // Read data valid.
    input  wire logic                  rready,   // Read data ready.
    output var  logic [31:0]           rdata,    // Read data.
    output var  logic [1:0]            rresp,    // Read response.
    input  wire bto_pkg::bto_bus_in_t  bus_in,   // Bus lines from the pins.
    output bto_pkg::bto_bus_out_t      bus_out   // Bus lines to the pins.
);

    localparam int DLY_CYC = `BTO_DAV_DELAY_CYC;
    localparam int PLS_CYC = `BTO_PULSE_CYC;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    bto_pkg::bto_bus_in_t bus_s;
    logic [$bits(bto_pkg::bto_bus_in_t)-1:0] bus_q;

    bto_sync2 #(.W($bits(bto_pkg::bto_bus_in_t))) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       (bus_in),
        .q       (bus_q)
    );

    assign bus_s = bto_pkg::bto_bus_in_t'(bus_q);

    wire ifc_s  = bus_s.ifc;
    wire atn_s  = bus_s.atn;
    wire dav_s  = bus_s.dav;
    wire nrfd_s = bus_s.nrfd;
    wire ndac_s = bus_s.ndac;
    wire disc   = !bus_s.connected;

    // ----------------------------------------------------------------
    // Registers and AXI4-Lite decode
    // ----------------------------------------------------------------
    logic [15:0] ctrl;
    logic [3:0]  meas_code;
    logic        byte_ready;
    logic        accepted;
    logic        talk_ff;
    logic        dav_prev;
    logic [7:0]  dio_q;
    bto_pkg::bto_hs_state_t state;
    bto_pkg::bto_hs_state_t next_state;

    wire wr_take = awvalid && wvalid && !bvalid;
    wire rd_take = arvalid && !rvalid;

    assign awready = wr_take;
    assign wready  = wr_take;
    assign arready = !rvalid;

    wire wr_ctrl = wr_take && (awaddr == `BTO_ADDR_CTRL);
    wire wr_data = wr_take && (awaddr == `BTO_ADDR_DATA);
    wire wr_stat = wr_take && (awaddr == `BTO_ADDR_STATUS);
    wire wr_ok   = wr_ctrl || wr_data || wr_stat;

    wire rd_ctrl = araddr == `BTO_ADDR_CTRL;
    wire rd_data = araddr == `BTO_ADDR_DATA;
    wire rd_stat = araddr == `BTO_ADDR_STATUS;
    wire rd_ok   = rd_ctrl || rd_data || rd_stat;

    wire        addressed_talk_mode = ctrl[`BTO_CTRL_ADDRESSED_TALK_MODE];
    wire [3:0]  my_address  = ctrl[`BTO_CTRL_ADDR_LSB +: 4];
    wire        gate        = ctrl[`BTO_CTRL_GATE];
    wire [3:0]  seq_code    = ctrl[`BTO_CTRL_SEQ_LSB +: 4];

    wire [15:0] ctrl_wmask = {{8{wstrb[1]}}, {8{wstrb[0]}}};
    wire [15:0] next_ctrl  = (ctrl & ~ctrl_wmask) | (wdata[15:0] & ctrl_wmask);

    // ----------------------------------------------------------------
    // Talk addressing
    // ----------------------------------------------------------------
    wire dav_fall  = dav_prev && !dav_s;
    wire addr_match = (bus_s.dio[3:0] == my_address);
    logic dly_expire;
    logic pulse;

    // The address code needs time to settle before it is gated.
    bto_timer #(.N(DLY_CYC)) u_dav_delay (
        .aclk    (aclk),
        .aresetn (aresetn),
        .start   (dav_fall),
        .abort   (dav_s),
        .active  (),
        .expire  (dly_expire)
    );

    bto_timer #(.N(PLS_CYC)) u_pulse (
        .aclk    (aclk),
        .aresetn (aresetn),
        .start   (dly_expire),
        .abort   (1'b0),
        .active  (pulse),
        .expire  ()
    );

    wire talk_set = pulse && !atn_s && addr_match;

    // Talk-always mode ignores the flip-flop; IFC still silences drivers.
    wire talk_enable = !addressed_talk_mode || talk_ff;
    wire request_n   = !talk_enable;
    wire drivers_en  = talk_enable && atn_s && !ifc_s;

    // ----------------------------------------------------------------
    // Code conversion
    // ----------------------------------------------------------------
    wire       rom_sel = seq_code[3];
    wire [1:0] rom_en  = rom_sel ? 2'h2 : 2'h1;

    function automatic logic [6:0] rom_numeric(input logic [3:0] c);
        logic [6:0] r;
        r = 7'h20;
        if (c <= 4'h9)
            r = {3'h3, c};
        else if (c == 4'hA)
            r = 7'h2E;
        else if (c == 4'hB)
            r = 7'h2D;
        else if (c == 4'hC)
            r = 7'h2B;
        else if (c == 4'hD)
            r = 7'h45;
        return r;
    endfunction

    function automatic logic [6:0] rom_control(input logic [3:0] c);
        logic [6:0] r;
        r = 7'h20;
        if (c == 4'h0)
            r = 7'h0D;
        else if (c == 4'h1)
            r = 7'h0A;
        else if (c == 4'h2)
            r = 7'h2C;
        return r;
    endfunction

    wire [6:0] rom_a = rom_numeric(wdata[3:0]);
    wire [6:0] rom_b = rom_control(wdata[3:0]);
    wire [2:0] upper = rom_en[1] ? rom_b[6:4] : rom_a[6:4];
    wire [3:0] lower = rom_sel ? rom_b[3:0] : rom_a[3:0];
    wire [7:0] next_dio = {1'b0, upper, lower};

    // ----------------------------------------------------------------
    // Three-wire handshake
    // ----------------------------------------------------------------
    wire dav_low  = (state == bto_pkg::HS_VALID) && byte_ready && !gate;
    wire accept   = dav_low && ndac_s;
    wire load_ok  = wr_data && !byte_ready;
    wire lrg      = (state == bto_pkg::HS_VALID) || disc;
    wire acc_view = accepted || disc;

    always_comb
    begin
        next_state = state;
        case (state)
            bto_pkg::HS_IDLE:
                if (byte_ready && drivers_en)
                    next_state = bto_pkg::HS_WAIT_RFD;
            bto_pkg::HS_WAIT_RFD:
                if (!drivers_en)
                    next_state = bto_pkg::HS_IDLE;
                else if (nrfd_s)
                    next_state = bto_pkg::HS_VALID;
            bto_pkg::HS_VALID:
                if (accept || !drivers_en)
                    next_state = bto_pkg::HS_IDLE;
            default:
                next_state = bto_pkg::HS_IDLE;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state      <= bto_pkg::HS_IDLE;
            byte_ready <= 1'b0;
            accepted   <= 1'b0;
            talk_ff    <= 1'b0;
            dav_prev   <= 1'b0;
        end
        else
        begin
            state    <= next_state;
            dav_prev <= dav_s;
            if (accept)
                byte_ready <= 1'b0;
            else if (load_ok)
                byte_ready <= 1'b1;
            // Set wins over a software clear arriving in the same cycle.
            if (accept)
                accepted <= 1'b1;
            else if (wr_stat && wstrb[0] && wdata[`BTO_ST_ACCEPTED])
                accepted <= 1'b0;
            if (ifc_s)
                talk_ff <= 1'b0;
            else if (talk_set)
                talk_ff <= 1'b1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl      <= `BTO_CTRL_RESET;
            meas_code <= 4'h0;
            dio_q     <= 8'h00;
        end
        else
        begin
            if (wr_ctrl)
                ctrl <= next_ctrl;
            // A byte on the bus is never changed while it is pending.
            if (load_ok && wstrb[0])
            begin
                meas_code <= wdata[3:0];
                dio_q     <= next_dio;
            end
        end
    end

    // ----------------------------------------------------------------
    // Bus responses and pins
    // ----------------------------------------------------------------
    wire [31:0] status_word = {25'h0, talk_ff, byte_ready, acc_view, lrg,
                               drivers_en, request_n, talk_enable};
    wire [31:0] rd_word = rd_ctrl ? {16'h0, ctrl} :
                          rd_data ? {20'h0, seq_code, dio_q[3:0], meas_code} :
                          rd_stat ? status_word : 32'h0000_0000;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid <= 1'b0;
            bresp  <= 2'h0;
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= 2'h0;
        end
        else
        begin
            if (wr_take)
            begin
                bvalid <= 1'b1;
                bresp  <= wr_ok ? 2'h0 : 2'h2;
            end
            else if (bready)
                bvalid <= 1'b0;
            if (rd_take)
            begin
                rvalid <= 1'b1;
                rdata  <= rd_word;
                rresp  <= rd_ok ? 2'h0 : 2'h2;
            end
            else if (rready)
                rvalid <= 1'b0;
        end
    end

    assign bus_out.dio    = dio_q;
    assign bus_out.dio_oe = drivers_en;
    assign bus_out.dav    = !dav_low;
    assign bus_out.dav_oe = drivers_en;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    AST_TALK_ALWAYS: assert property (@(posedge aclk) disable iff (!aresetn)
        !addressed_talk_mode |-> talk_enable && !request_n)
        else $error("Talk-always mode without talk enable.");

    AST_DRIVERS: assert property (@(posedge aclk) disable iff (!aresetn)
        bus_out.dio_oe |-> talk_enable && atn_s && !ifc_s)
        else $error("Drivers active without talk and ATN high.");

    AST_IFC_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
        ifc_s |-> !bus_out.dio_oe ##1 !talk_ff)
        else $error("IFC did not clear talk state.");

    AST_DELAY_PULSE: assert property (@(posedge aclk) disable iff (!aresetn)
        $fell(dav_s) ##1 (!dav_s)[*5] |=> pulse)
        else $error("Delayed DAV pulse not started after 500 ns.");

    AST_PULSE_LEN: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(pulse) |-> pulse[*5] ##1 !pulse)
        else $error("Address pulse is not 500 ns long.");

    AST_TALK_SET: assert property (@(posedge aclk) disable iff (!aresetn)
        pulse && !atn_s && addr_match && !ifc_s |=> talk_ff)
        else $error("Talk flip-flop not set by matched pulse.");

    AST_DAV_VALID: assert property (@(posedge aclk) disable iff (!aresetn)
        !bus_out.dav |-> byte_ready && !gate && ($past(nrfd_s) || !$past(bus_out.dav)))
        else $error("DAV low without a ready byte.");

    AST_ACCEPT: assert property (@(posedge aclk) disable iff (!aresetn)
        !bus_out.dav && ndac_s |=> accepted && !byte_ready && bus_out.dav)
        else $error("NDAC high did not complete the byte.");

    AST_DISCONNECT: assert property (@(posedge aclk) disable iff (!aresetn)
        disc |-> status_word[`BTO_ST_LISTENER_RDY] && status_word[`BTO_ST_ACCEPTED])
        else $error("Disconnected bus did not force flags high.");

    AST_ONE_ROM: assert property (@(posedge aclk) disable iff (!aresetn)
        $onehot(rom_en) && (rom_en[1] == seq_code[3]))
        else $error("Conversion ROM enables not exclusive.");

    COV_ADDRESSED: cover property (@(posedge aclk) disable iff (!aresetn)
        $rose(talk_ff));
    COV_BYTE_DONE: cover property (@(posedge aclk) disable iff (!aresetn)
        accept);
    COV_TALK_ONLY_SEND: cover property (@(posedge aclk) disable iff (!aresetn)
        !addressed_talk_mode && accept);

endmodule

`default_nettype wire

// file: shared/bto_params.svh
`ifndef BTO_PARAMS_SVH
`define BTO_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define BTO_ADDR_CTRL        8'h00
`define BTO_ADDR_DATA        8'h04
`define BTO_ADDR_STATUS      8'h08

// ----------------------------------------------------------------
// Control register fields and reset value
// ----------------------------------------------------------------
`define BTO_CTRL_ADDRESSED_TALK_MODE 0
`define BTO_CTRL_ADDR_LSB    1
`define BTO_CTRL_GATE        5
`define BTO_CTRL_SEQ_LSB     8
`define BTO_CTRL_RESET       16'h0021

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define BTO_ST_TALK_EN       0
`define BTO_ST_REQUEST_N     1
`define BTO_ST_DRIVERS       2
`define BTO_ST_LISTENER_RDY  3
`define BTO_ST_ACCEPTED      4
`define BTO_ST_BYTE_READY    5
`define BTO_ST_TALK_FF       6

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define BTO_CLK_PERIOD_NS    100
`define BTO_DAV_DELAY_NS     500
`define BTO_PULSE_NS         500
`define BTO_DAV_DELAY_CYC    ((`BTO_DAV_DELAY_NS + `BTO_CLK_PERIOD_NS - 1) / `BTO_CLK_PERIOD_NS)
`define BTO_PULSE_CYC        (`BTO_PULSE_NS / `BTO_CLK_PERIOD_NS)

`endif

// file: shared/bto_pkg.sv
`default_nettype none

package bto_pkg;

    // Bus lines as seen at the pins, in wire-level sense.
    typedef struct packed {
        logic       ifc;
        logic       atn;
        logic       dav;
        logic       nrfd;
        logic       ndac;
        logic       connected;
        logic [7:0] dio;
    } bto_bus_in_t;

    typedef struct packed {
        logic [7:0] dio;
        logic       dio_oe;
        logic       dav;
        logic       dav_oe;
    } bto_bus_out_t;

    typedef enum logic [1:0] {
        HS_IDLE,
        HS_WAIT_RFD,
        HS_VALID
    } bto_hs_state_t;

endpackage

`default_nettype wire

// file: core/bto_sync2.sv
`default_nettype none

module bto_sync2 #(
    parameter int W = 1
) (
    input  wire logic         aclk,     // System clock.
    input  wire logic         aresetn,  // Synchronous reset, active low.
    input  wire logic [W-1:0] d,        // Asynchronous inputs.
    output var  logic [W-1:0] q         // Synchronised outputs.
);

    logic [W-1:0] meta;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            meta <= '0;
            q    <= '0;
        end
        else
        begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule

`default_nettype wire

// file: core/bto_timer.sv
`default_nettype none

module bto_timer #(
    parameter int N = 5
) (
    input  wire logic aclk,     // System clock.
    input  wire logic aresetn,  // Synchronous reset, active low.
    input  wire logic start,    // Load and run for N cycles.
    input  wire logic abort,    // Drop a running count.
    output var  logic active,   // High while counting.
    output logic      expire    // One cycle at the end of the count.
);

    localparam int CW = $clog2(N + 1);

    logic [CW-1:0] cnt;
    wire           last = (cnt == CW'(1));

    assign expire = active && last && !abort;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt    <= '0;
            active <= 1'b0;
        end
        else if (start)
        begin
            cnt    <= CW'(N);
            active <= 1'b1;
        end
        else if (active && (abort || last))
        begin
            active <= 1'b0;
        end
        else if (active)
        begin
            cnt <= cnt - CW'(1);
        end
    end

endmodule

`default_nettype wire

// file: sim/bto_bus_model.sv
`default_nettype none

// ----------------------------------------------------------------
// Bus controller and one listener
// ----------------------------------------------------------------
module bto_bus_model (
    input  wire logic                  aclk,       // System clock.
    input  wire bto_pkg::bto_bus_out_t bus_out,    // Talker pin outputs.
    input  wire logic                  ifc_req,    // Interface clear from the bench.
    input  wire logic                  connected,  // Cable present.
    input  wire logic                  slow,       // Listener answers late.
    output bto_pkg::bto_bus_in_t       bus_in,     // Wire levels to the talker.
    output logic [7:0]                 last_byte,  // Last byte taken.
    output int                         byte_count  // Bytes taken.
);
    timeunit 1ns;
    timeprecision 1ns;

    logic       ctl_atn = 1'b1;
    logic       ctl_dav = 1'b1;
    logic [3:0] ctl_code = 4'h0;
    logic       nrfd = 1'b0;
    logic       ndac = 1'b0;
    int         cnt = 0;
    logic       wire_dav;
    logic [7:0] wire_dio;

    // Released lines float to the terminator level, which reads high.
    assign wire_dav = ctl_dav & (bus_out.dav_oe ? bus_out.dav : 1'b1);
    assign wire_dio = !ctl_atn ? {4'hF, ctl_code} : (bus_out.dio_oe ? bus_out.dio : 8'hFF);
    assign bus_in = {ifc_req, ctl_atn, wire_dav, nrfd, ndac, connected, wire_dio};

    initial
    begin
        last_byte = 8'h00;
        byte_count = 0;
    end

    // The address and DAV are held well past the talker's delay and pulse window.
    task automatic address_talker(input logic [3:0] code);
        @(posedge aclk);
        ctl_code <= code;
        ctl_atn <= 1'b0;
        @(posedge aclk);
        ctl_dav <= 1'b0;
        repeat (16) @(posedge aclk);
        ctl_atn <= 1'b1;
        ctl_dav <= 1'b1;
    endtask

    always @(posedge aclk)
    begin
        if (!bus_out.dav_oe)
        begin
            nrfd <= 1'b0;
            ndac <= 1'b0;
            cnt <= 0;
        end
        else if (ndac)
        begin
            if (wire_dav)
            begin
                ndac <= 1'b0;
                cnt <= 0;
            end
        end
        else if (!wire_dav && nrfd)
        begin
            last_byte <= wire_dio;
            byte_count <= byte_count + 1;
            nrfd <= 1'b0;
            cnt <= 0;
        end
        else if (cnt >= (slow ? 6 : 1))
        begin
            if (!wire_dav)
                ndac <= 1'b1;
            else
                nrfd <= 1'b1;
        end
        else
            cnt <= cnt + 1;
    end
endmodule

`default_nettype wire

// file: sim/tb_top.sv
`include "bto_params.svh"
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    logic                  aclk, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic                  arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
    logic [7:0]            awaddr = 8'h00, araddr = 8'h00, last_byte;
    logic [31:0]           wdata = 32'h0, rdata, rd;
    logic [1:0]            bresp, rresp, rs;
    logic                  ifc_req = 1'b0, connected = 1'b1, slow = 1'b0;
    bto_pkg::bto_bus_in_t  bus_in;
    bto_pkg::bto_bus_out_t bus_out;
    int                    byte_count, fail_count = 0, total_checks = 0, cycles = 0;
    logic [7:0]            num_rom [16] = '{8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36,
        8'h37, 8'h38, 8'h39, 8'h2E, 8'h2D, 8'h2B, 8'h45, 8'h20, 8'h20};
    logic [7:0]            ctl_rom [4] = '{8'h0D, 8'h0A, 8'h2C, 8'h20};

    bto_talker DUT (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(4'hF), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
        .rdata(rdata), .rresp(rresp), .bus_in(bus_in), .bus_out(bus_out));

    bto_bus_model bfm (.aclk(aclk), .bus_out(bus_out), .ifc_req(ifc_req),
        .connected(connected), .slow(slow), .bus_in(bus_in), .last_byte(last_byte),
        .byte_count(byte_count));

    initial
    begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    // ----------------------------------------------------------------
    // Closing report and hang guard
    // ----------------------------------------------------------------
    task automatic close_out();
        $display("checks %0d errors %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    always @(posedge aclk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            fail_count++;
            $display("unexpected timeout at %0t: %h %h", $time, cycles, 32'h0);
            close_out();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // ----------------------------------------------------------------
    // Register access
    // ----------------------------------------------------------------
    // Handshakes are sampled on the falling edge, where nothing changes.
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        logic hs;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(negedge aclk);
            hs = awready & wready;
            @(posedge aclk);
        end while (hs !== 1'b1);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do
        begin
            @(negedge aclk);
            hs = bvalid;
            rs = bresp;
            @(posedge aclk);
        end while (hs !== 1'b1);
        bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [7:0] a);
        logic hs;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(negedge aclk);
            hs = arready;
            @(posedge aclk);
        end while (hs !== 1'b1);
        arvalid <= 1'b0;
        do
        begin
            @(negedge aclk);
            hs = rvalid;
            rd = rdata;
            rs = rresp;
            @(posedge aclk);
        end while (hs !== 1'b1);
        rready <= 1'b0;
    endtask

    task automatic status_after(input int n);
        repeat (n) @(posedge aclk);
        axi_read(`BTO_ADDR_STATUS);
    endtask

    // Sends one code and waits, bounded, for the listener to take it.
    task automatic send_byte(input logic [3:0] code);
        int n;
        n = 0;
        // Clear the accepted flag first, so that the check below sees a fresh set.
        axi_write(`BTO_ADDR_STATUS, 32'h10);
        axi_write(`BTO_ADDR_DATA, {28'h0, code});
        do
        begin
            status_after(1);
            n++;
        end while (rd[5] !== 1'b0 && n < 100);
        check(rd & 32'h10, 32'h10);
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axi_read(`BTO_ADDR_CTRL);
        check(rd, 32'h21);
        axi_read(8'h0C);
        check({30'h0, rs}, 32'h2);
        axi_write(8'h0C, 32'h0);
        check({30'h0, rs}, 32'h2);
        axi_write(`BTO_ADDR_CTRL, 32'h20);
        check({30'h0, rs}, 32'h0);
        status_after(4);
        check(rd & 32'h47, 32'h05);
        axi_write(`BTO_ADDR_DATA, 32'h5);
        repeat (30) @(posedge aclk);
        check(byte_count, 0);
        axi_write(`BTO_ADDR_CTRL, 32'h0);
        send_byte(4'h5);
        check({24'h0, last_byte}, 32'h35);
        for (int c = 0; c < 16; c++)
        begin
            send_byte(c[3:0]);
            check({24'h0, last_byte}, {24'h0, num_rom[c]});
            check(byte_count, c + 2);
        end
        slow <= 1'b1;
        axi_write(`BTO_ADDR_CTRL, 32'h800);
        for (int c = 0; c < 4; c++)
        begin
            send_byte(c[3:0]);
            check({24'h0, last_byte}, {24'h0, ctl_rom[c]});
        end
        axi_read(`BTO_ADDR_DATA);
        check(rd, 32'h803);
        slow <= 1'b0;
        axi_write(`BTO_ADDR_STATUS, 32'h10);
        status_after(1);
        check(rd & 32'h10, 32'h0);
        connected <= 1'b0;
        status_after(4);
        check(rd & 32'h18, 32'h18);
        connected <= 1'b1;
        axi_write(`BTO_ADDR_CTRL, 32'h13);
        status_after(4);
        check(rd & 32'h47, 32'h02);
        bfm.address_talker(4'h3);
        status_after(4);
        check(rd & 32'h41, 32'h0);
        bfm.address_talker(4'h9);
        status_after(4);
        check(rd & 32'h47, 32'h45);
        send_byte(4'h1);
        check({24'h0, last_byte}, 32'h31);
        ifc_req <= 1'b1;
        status_after(4);
        check(rd & 32'h45, 32'h0);
        ifc_req <= 1'b0;
        status_after(4);
        check(rd & 32'h41, 32'h0);
        close_out();
    end
endmodule

`default_nettype wire
